// >>> core/boot_seq_pkg.sv
// Purpose: Shared constants for the enable, reset and boot sequencer.
// Assumes: One 40 MHz clock; all pin inputs synchronous to it.
// Notes:   Long counts are module parameters; these are their defaults.
package boot_seq_pkg;

    // Clock period in picoseconds, 25 ns at 40 MHz.
    localparam int unsigned CLK_PERIOD_PS = 25_000;

    // Boot interval after enable rises, in microseconds.
    localparam int unsigned BOOT_TIME_US = 2_500;

    // Boot interval in clock cycles; a least time, so it rounds up.
    localparam int unsigned BOOT_CYCLES =
        (BOOT_TIME_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Shortest enable-low time that counts as a reset, in nanoseconds.
    localparam int unsigned ENABLE_LOW_PULSE_TIME_NS = 100;

    // Enable-low time in cycles, rounded up, at least one.
    localparam int unsigned ENABLE_LOW_CYCLES =
        (ENABLE_LOW_PULSE_TIME_NS * 1_000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;

    // Width of the boot counter.
    localparam int unsigned CNT_W = 24;

    // Number of configuration words held in the defaults store.
    localparam int unsigned CFG_WORDS = 8;
    localparam int unsigned CFG_AW    = 3;
    localparam int unsigned CFG_DW    = 8;

    // Fixed hardware default for configuration words not loaded.
    localparam logic [CFG_DW-1:0] CFG_HW_DEFAULT = 8'h00;

    // Words at or above this index are loaded; those below are fixed.
    localparam logic [CFG_AW-1:0] CFG_LOADED_FIRST = 3'h4;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_POWER_DOWN = 3'b000,
        ST_LOAD       = 3'b001,
        ST_BOOT_WAIT  = 3'b010,
        ST_RUN        = 3'b011,
        ST_DOWNLOAD   = 3'b100
    } seq_state_e;

endpackage : boot_seq_pkg

// >>> core/cfg_store.sv
// Purpose: Small nonvolatile-image store for configuration defaults.
// Assumes: One write port, one read port, registered read data.
// Notes:   Contents survive enable-low resets; only the sequencer reads.
`timescale 1ns/1ps
module cfg_store
    import boot_seq_pkg::*;
(
    input  wire logic              clk_in,   // System clock.
    input  wire logic              wr_en_in, // Write strobe.
    input  wire logic [CFG_AW-1:0] wr_adr_in,// Write address.
    input  wire logic [CFG_DW-1:0] wr_dat_in,// Write data.
    input  wire logic [CFG_AW-1:0] rd_adr_in,// Read address.
    output logic      [CFG_DW-1:0] rd_dat_out // Registered read data.
);

    logic [CFG_DW-1:0] mem [CFG_WORDS];

    // No reset on purpose: the image must outlive a hard power down.
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_adr_in] <= wr_dat_in;
        end
        rd_dat_out <= mem[rd_adr_in];
    end

endmodule : cfg_store

// >>> core/enable_reset_boot_sequencer.sv
// Purpose: Hard power down, boot and firmware-download entry sequencing.
// Assumes: Enable and request pins already synchronous to ref_clk_in.
// Notes:   Behaviour
`timescale 1ns/1ps
module enable_reset_boot_sequencer
    import boot_seq_pkg::*;
#(
    parameter int unsigned BOOT_WAIT = BOOT_CYCLES // Boot wait cycles.
)
(
    input  wire logic              ref_clk_in,      // 40 MHz clock.
    input  wire logic              arst_n_in,       // Async reset, low.
    input  wire logic              chip_enable_pin_in,   // Enable pin.
    input  wire logic              firmware_load_request_in, // Dl req.
    input  wire logic              pad_supply_ok_in,     // Pad supply up.
    input  wire logic [1:0]        if_select_in,    // Interface straps.
    input  wire logic              nv_wr_en_in,     // Download write.
    input  wire logic [CFG_AW-1:0] nv_wr_adr_in,    // Download address.
    input  wire logic [CFG_DW-1:0] nv_wr_dat_in,    // Download data.
    input  wire logic [CFG_AW-1:0] cfg_rd_adr_in,   // Default index.
    output logic      [CFG_DW-1:0] cfg_rd_dat_out,  // Default value.
    output logic                   fw_reset_out,    // Firmware in reset.
    output logic                   host_ready_out,  // Host may talk.
    output logic                   download_mode_out, // Download active.
    output logic [1:0]             if_select_out,   // Latched selection.
    output logic                   if_select_lost_out // Selection stale.
);

    seq_state_e        state;
    seq_state_e        next_state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  next_cnt;
    logic              dl_req;
    logic              next_dl_req;
    logic [1:0]        if_sel;
    logic [1:0]        next_if_sel;
    logic              sel_lost;
    logic              next_sel_lost;
    logic [CFG_DW-1:0] cfg [CFG_WORDS];
    logic [CFG_DW-1:0] next_cfg [CFG_WORDS];
    logic [CFG_AW-1:0] load_adr;
    logic [CFG_AW-1:0] next_load_adr;
    logic              load_valid;
    logic              next_load_valid;
    logic [CFG_DW-1:0] nv_rd_dat;
    logic              nv_we;

    localparam logic [CNT_W-1:0] BOOT_LAST = CNT_W'(BOOT_WAIT - 1);
    localparam logic [CFG_AW-1:0] LOAD_LAST = CFG_AW'(CFG_WORDS - 1);

    // Only download mode may write the store.
    assign nv_we = (state == ST_DOWNLOAD) && nv_wr_en_in;

    cfg_store u_store (
        .clk_in     (ref_clk_in),
        .wr_en_in   (nv_we),
        .wr_adr_in  (nv_wr_adr_in),
        .wr_dat_in  (nv_wr_dat_in),
        .rd_adr_in  (load_adr),
        .rd_dat_out (nv_rd_dat)
    );

    // Sequencer next state. Enable low wins over every other condition,
    // so a short glitch always lands in power down.
    always_comb begin
        next_state      = state;
        next_cnt        = cnt;
        next_dl_req     = dl_req;
        next_if_sel     = if_sel;
        next_sel_lost   = sel_lost;
        next_load_adr   = load_adr;
        next_load_valid = 1'b0;
        for (int i = 0; i < CFG_WORDS; i++) begin
            next_cfg[i] = cfg[i];
        end
        if (!chip_enable_pin_in) begin
            next_state    = ST_POWER_DOWN;
            next_cnt      = '0;
            next_dl_req   = 1'b0;
            next_load_adr = '0;
            for (int i = 0; i < CFG_WORDS; i++) begin
                next_cfg[i] = CFG_HW_DEFAULT;
            end
        end else begin
            unique case (state)
                ST_POWER_DOWN: begin
                    // Request and straps sampled as boot starts.
                    next_dl_req   = firmware_load_request_in;
                    next_if_sel   = if_select_in;
                    next_sel_lost = ~pad_supply_ok_in;
                    next_load_adr = '0;
                    next_state    = ST_LOAD;
                end
                ST_LOAD: begin
                    // Read data lag the address by one cycle.
                    next_load_valid = 1'b1;
                    if (load_valid) begin
                        next_load_valid = 1'b0;
                        if ((load_adr - 1'b1) >= CFG_LOADED_FIRST) begin
                            next_cfg[load_adr - 1'b1] = nv_rd_dat;
                        end
                        // Address has already wrapped to zero when the last word lands.
                        if (load_adr == '0) begin
                            next_state = ST_BOOT_WAIT;
                            next_cnt   = '0;
                        end
                    end else begin
                        next_load_adr = load_adr + 1'b1;
                        if (load_adr == LOAD_LAST) begin
                            next_load_adr = '0;
                        end
                    end
                end
                ST_BOOT_WAIT: begin
                    next_cnt = cnt + 1'b1;
                    if (cnt == BOOT_LAST) begin
                        next_state = dl_req ? ST_DOWNLOAD : ST_RUN;
                    end
                end
                ST_RUN, ST_DOWNLOAD: begin
                    next_state = state;
                end
                default: next_state = ST_POWER_DOWN;
            endcase
            // A pad drop while enabled spoils the latched selection.
            if (!pad_supply_ok_in) begin
                next_sel_lost = 1'b1;
            end
        end
    end

    // Registers for the sequencer state.
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state      <= ST_POWER_DOWN;
            cnt        <= '0;
            dl_req     <= 1'b0;
            if_sel     <= 2'b00;
            sel_lost   <= 1'b0;
            load_adr   <= '0;
            load_valid <= 1'b0;
            for (int i = 0; i < CFG_WORDS; i++) begin
                cfg[i] <= CFG_HW_DEFAULT;
            end
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            dl_req     <= next_dl_req;
            if_sel     <= next_if_sel;
            sel_lost   <= next_sel_lost;
            load_adr   <= next_load_adr;
            load_valid <= next_load_valid;
            for (int i = 0; i < CFG_WORDS; i++) begin
                cfg[i] <= next_cfg[i];
            end
        end
    end

    // Registered outputs derived from the state.
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fw_reset_out      <= 1'b1;
            host_ready_out    <= 1'b0;
            download_mode_out <= 1'b0;
            if_select_out     <= 2'b00;
            if_select_lost_out <= 1'b0;
            cfg_rd_dat_out    <= CFG_HW_DEFAULT;
        end else begin
            fw_reset_out      <= (next_state == ST_POWER_DOWN);
            host_ready_out    <= (next_state == ST_RUN) ||
                                 (next_state == ST_DOWNLOAD);
            download_mode_out <= (next_state == ST_DOWNLOAD);
            if_select_out     <= next_if_sel;
            if_select_lost_out <= next_sel_lost;
            cfg_rd_dat_out    <= cfg[cfg_rd_adr_in];
        end
    end

    // Firmware stays in reset the cycle after enable is seen low.
    property p_enable_low_reset;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !chip_enable_pin_in |=> fw_reset_out && !host_ready_out;
    endproperty
    a_enable_low_reset: assert property (p_enable_low_reset)
        else $error("Firmware not held in reset with enable low.");

    // Defaults return to hardware value under enable low; the last word is
    // one of the loaded ones, so this also catches a stale loaded value.
    property p_defaults_cleared;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        !chip_enable_pin_in |=> cfg[CFG_WORDS-1] == CFG_HW_DEFAULT;
    endproperty
    a_defaults_cleared: assert property (p_defaults_cleared)
        else $error("Defaults not restored during power down.");

    // Host readiness only follows a boot wait that has run its full count.
    property p_boot_wait;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        $rose(host_ready_out) |->
            $past(state) == ST_BOOT_WAIT && $past(cnt) == BOOT_LAST;
    endproperty
    a_boot_wait: assert property (p_boot_wait)
        else $error("Host ready before boot wait elapsed.");

    // Download mode only entered when the request was sampled.
    property p_dl_entry;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        $rose(download_mode_out) |-> $past(dl_req);
    endproperty
    a_dl_entry: assert property (p_dl_entry)
        else $error("Download mode without sampled request.");

    // Store written only in download mode.
    property p_store_guard;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        nv_we |-> state == ST_DOWNLOAD;
    endproperty
    a_store_guard: assert property (p_store_guard)
        else $error("Store written outside download mode.");

    // Pad drop marks the selection stale next cycle.
    property p_sel_lost;
        @(posedge ref_clk_in) disable iff (!arst_n_in)
        (chip_enable_pin_in && !pad_supply_ok_in) |=> if_select_lost_out;
    endproperty
    a_sel_lost: assert property (p_sel_lost)
        else $error("Pad drop not flagged.");

endmodule : enable_reset_boot_sequencer

// >>> testbench/host_seq_model.sv
// Purpose: Behavioural host that sequences enable, straps and supplies.
// Assumes: Drives every pin just after a falling edge of ref_clk_in.
// Notes:   Unsupplied strap pins show the inverse of the intended value.
`timescale 1ns/1ps
module host_seq_model #(
    parameter int unsigned BOOT_WAIT  = 10, // Boot wait cycles.
    parameter int unsigned EN_LOW_CYC = 4   // Enable-low cycles.
)
(
    input  wire logic       ref_clk_in,                // System clock.
    input  wire logic       host_ready_in,             // Boot complete.
    output logic            chip_enable_pin_out,       // Enable pin.
    output logic            firmware_load_request_out, // Download request.
    output logic            pad_supply_ok_out,         // Pad supply up.
    output logic [1:0]      if_select_out              // Interface straps.
);
    logic       vbat_ok;
    logic [1:0] straps;

    // Power starts absent except the battery, which is always present.
    initial begin
        vbat_ok = 1'b1;
        straps = 2'b00;
        chip_enable_pin_out = 1'b0;
        firmware_load_request_out = 1'b0;
        pad_supply_ok_out = 1'b0;
        if_select_out = ~straps;
    end

    // A full reset pulse then boot; returns cycles waited for readiness.
    task automatic boot(input logic dl, input logic [1:0] sel,
                        output int wait_cyc);
        @(negedge ref_clk_in);
        chip_enable_pin_out = 1'b0;
        repeat (EN_LOW_CYC) @(negedge ref_clk_in);
        pad_supply_ok_out = 1'b1;
        straps = sel;
        if_select_out = sel;
        firmware_load_request_out = dl; // Held before enable rises.
        @(negedge ref_clk_in);
        if (vbat_ok) begin
            chip_enable_pin_out = 1'b1;
        end
        wait_cyc = 0;
        // No traffic until readiness; bounded so a hang cannot stall.
        while (host_ready_in !== 1'b1 && wait_cyc < BOOT_WAIT + 1000) begin
            @(negedge ref_clk_in);
            wait_cyc++;
        end
    endtask : boot

    // Enable low while the pad supply stays up.
    task automatic hold_reset();
        @(negedge ref_clk_in);
        chip_enable_pin_out = 1'b0;
        @(negedge ref_clk_in);
    endtask : hold_reset

    // Pad supply dips while enabled; caller must boot again.
    task automatic pad_drop();
        @(negedge ref_clk_in);
        pad_supply_ok_out = 1'b0;
        if_select_out = ~straps;
        repeat (3) @(negedge ref_clk_in);
        pad_supply_ok_out = 1'b1;
        if_select_out = straps;
        @(negedge ref_clk_in);
    endtask : pad_drop

    // Enable goes low a full cycle before the pad supply goes.
    task automatic power_down();
        @(negedge ref_clk_in);
        chip_enable_pin_out = 1'b0;
        @(negedge ref_clk_in);
        pad_supply_ok_out = 1'b0;
        if_select_out = ~straps;
        @(negedge ref_clk_in);
    endtask : power_down

endmodule : host_seq_model

// >>> testbench/enable_reset_boot_sequencer_tb.sv
// Purpose: Self-checking bench for the enable, reset and boot sequencer.
// Assumes: Short boot wait of 10 cycles; inputs change on falling edges.
// Notes:   Boot length is exact: one entry cycle, two per word, the wait.
`timescale 1ns/1ps
module enable_reset_boot_sequencer_tb;
    import boot_seq_pkg::*;
    localparam int unsigned BW = 10;
    localparam int unsigned LOAD_CYC = 1 + 2 * CFG_WORDS; // Entry and load.
    typedef struct {logic dl; logic [1:0] sel;} row_s;
    logic              ref_clk_in = 1'b0;
    logic              arst_n_in = 1'b0;
    logic              en, dlr, pad, nv_en, hrdy, fwr, dlm, lost;
    logic [1:0]        sel_in, sel_out, sel_pins;
    logic [CFG_AW-1:0] nv_adr, rd_adr;
    logic [CFG_DW-1:0] nv_dat, rd_dat;
    int                failures = 0;
    int                comparisons = 0;
    int                w;
    row_s              rows [4] = '{'{1'b0, 2'b00}, '{1'b1, 2'b01},
                                    '{1'b0, 2'b10}, '{1'b1, 2'b11}};

    // Free-running 40 MHz clock.
    always #12.5 ref_clk_in = ~ref_clk_in;

    enable_reset_boot_sequencer #(.BOOT_WAIT(BW)) i_dut (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .chip_enable_pin_in(en), .firmware_load_request_in(dlr),
        .pad_supply_ok_in(pad), .if_select_in(sel_pins),
        .nv_wr_en_in(nv_en), .nv_wr_adr_in(nv_adr), .nv_wr_dat_in(nv_dat),
        .cfg_rd_adr_in(rd_adr), .cfg_rd_dat_out(rd_dat),
        .fw_reset_out(fwr), .host_ready_out(hrdy),
        .download_mode_out(dlm), .if_select_out(sel_out),
        .if_select_lost_out(lost));

    host_seq_model #(.BOOT_WAIT(BW), .EN_LOW_CYC(4)) i_host (
        .ref_clk_in(ref_clk_in), .host_ready_in(hrdy),
        .chip_enable_pin_out(en), .firmware_load_request_out(dlr),
        .pad_supply_ok_out(pad), .if_select_out(sel_pins));

    // Counts every compare; a mismatch is reported at once.
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // One store write per cycle. The strobe stays high so that back to
    // back writes never lower and raise it in one time step; the caller
    // lowers it after the last write.
    task automatic nv_write(input logic [2:0] a, input logic [7:0] d);
        nv_en = 1'b1;
        nv_adr = a;
        nv_dat = d;
        @(negedge ref_clk_in);
    endtask : nv_write

    // Read data is registered, so it is looked at a full cycle later.
    task automatic rd_check(input logic [2:0] a, input logic [7:0] exp);
        rd_adr = a;
        @(negedge ref_clk_in);
        check("cfg_rd_dat", rd_dat, exp);
    endtask : rd_check

    // Readiness must come exactly after the entry cycle, the load and the wait.
    task automatic ready_check(input logic dl, input logic [1:0] sel);
        check("host_ready", 8'(hrdy), 8'h01);
        check("fw_reset", 8'(fwr), 8'h00);
        check("boot_len", 8'(w), 8'(BW + LOAD_CYC));
        check("download_mode", 8'(dlm), 8'(dl));
        check("if_select", 8'(sel_out), 8'(sel));
        check("if_select_lost", 8'(lost), 8'h00);
    endtask : ready_check

    task automatic end_of_test();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    // Whole run is a few hundred cycles; this leaves ample margin.
    initial begin
        #(20_000 * 25);
        failures++;
        end_of_test();
    end

    initial begin
        nv_en = 1'b0;
        nv_adr = '0;
        nv_dat = '0;
        rd_adr = '0;
        repeat (8) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        arst_n_in = 1'b1;
        @(negedge ref_clk_in);
        check("fw_reset", 8'(fwr), 8'h01);
        check("host_ready", 8'(hrdy), 8'h00);
        foreach (rows[i]) begin
            i_host.boot(rows[i].dl, rows[i].sel, w);
            ready_check(rows[i].dl, rows[i].sel);
        end
        // Download image, then a plain boot must pick it up.
        i_host.boot(1'b1, 2'b01, w);
        for (int k = 0; k < 8; k++) begin
            nv_write(3'(k), 8'hA0 + 8'(k));
        end
        nv_en = 1'b0;
        i_host.boot(1'b0, 2'b01, w);
        ready_check(1'b0, 2'b01);
        for (int k = 0; k < 8; k++) begin
            rd_check(3'(k), (k < 4) ? CFG_HW_DEFAULT : 8'hA0 + 8'(k));
        end
        // Outside download mode a write must leave the image alone.
        nv_write(3'h4, 8'h33);
        nv_en = 1'b0;
        i_host.boot(1'b0, 2'b01, w);
        rd_check(3'h4, 8'hA4);
        // Enable low mid-run returns to hard power down.
        i_host.hold_reset();
        check("fw_reset", 8'(fwr), 8'h01);
        check("host_ready", 8'(hrdy), 8'h00);
        check("download_mode", 8'(dlm), 8'h00);
        // Pad dip while enabled flags the selection; a new boot clears it.
        i_host.boot(1'b0, 2'b10, w);
        i_host.pad_drop();
        check("if_select_lost", 8'(lost), 8'h01);
        i_host.boot(1'b0, 2'b10, w);
        ready_check(1'b0, 2'b10);
        // Reset in mid-run: power down at once, then a full boot again.
        arst_n_in = 1'b0;
        @(negedge ref_clk_in);
        check("fw_reset", 8'(fwr), 8'h01);
        check("host_ready", 8'(hrdy), 8'h00);
        arst_n_in = 1'b1;
        repeat (LOAD_CYC + BW - 1) @(negedge ref_clk_in);
        check("host_ready", 8'(hrdy), 8'h00);
        @(negedge ref_clk_in);
        ready_check(1'b0, 2'b10);
        i_host.power_down();
        check("fw_reset", 8'(fwr), 8'h01);
        end_of_test();
    end
endmodule : enable_reset_boot_sequencer_tb
